// ### src/mpcg_pkg.sv
/*
  Constants, field layout and carrier types for the memory PLL configuration
  and clock gating control block.
  Assumes an AHB-Lite master with 32-bit data and single word transfers.
*/
package mpcg_pkg;
  localparam logic [31:0] MEM_CFG_ADDR = 32'h0000004C;
  localparam logic [31:0] GATE_ADDR = 32'h000000F8;
  localparam logic [31:0] MEM_CFG_RESET = 32'h00100000;
  localparam logic [31:0] GATE_RESET = 32'h00001800;
  localparam int DLL_PD_BIT = 21;
  localparam int LOCK_BIT = 20;
  localparam int BYPASS_BIT = 19;
  localparam int BAND_LSB = 16;
  localparam int OUT_DIV_LSB = 13;
  localparam int IN_DIV_LSB = 8;
  localparam int FB_DIV_LSB = 0;
  localparam int GATE_LSB = 22;
  localparam int SEL_LSB = 0;
  localparam int SEL_W = 3;
  localparam int DOMAINS = 6;
  localparam int SELS = 7;
  localparam int SEL_BITS = 21;
  localparam int PLL_SRCS = 5;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hready;
  } mpcg_ahb_req_type;

  typedef struct packed {
    logic dll_pd;
    logic pll_bypass;
    logic [2:0] band;
    logic [2:0] out_div;
    logic [4:0] loop_in_div;
    logic [7:0] loop_fb_div;
  } mpcg_pll_cfg_type;
endpackage

// ### src/mpcg_top.sv
/*
  Memory PLL configuration register and per-domain clock gate control,
  reached as an AHB-Lite slave with zero wait states.
  Assumes all inputs synchronous to clk, and source clock levels sampled
  on pll_clk_level that run slower than clk.
*/
`timescale 1ns/1ps
`default_nettype none
module mpcg_top (
  input wire logic clk,
  input wire logic rst,
  input wire mpcg_pkg::mpcg_ahb_req_type ahb_req,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic pll_locked,
  input wire logic [4:0] pll_clk_level,
  output var mpcg_pkg::mpcg_pll_cfg_type mem_pll_cfg,
  output logic [5:0] gate_hold,
  output logic [20:0] clk_sel
);
  logic [5:0] gate_ctl;
  logic wr_pend;
  logic wr_mem;
  logic wr_gate;
  logic take;
  logic [5:0] src_low;
  mpcg_pkg::mpcg_pll_cfg_type next_cfg;
  logic [20:0] next_sel;
  logic [5:0] next_gate;

  function automatic logic hits(input logic [31:0] a, input logic [31:0] target);
    hits = (a[31:2] == target[31:2]);
  endfunction

  function automatic mpcg_pkg::mpcg_pll_cfg_type cfg_from_word(input logic [31:0] w);
    mpcg_pkg::mpcg_pll_cfg_type c;
    c.dll_pd = w[mpcg_pkg::DLL_PD_BIT];
    c.pll_bypass = w[mpcg_pkg::BYPASS_BIT];
    c.band = w[mpcg_pkg::BAND_LSB +: 3];
    c.out_div = w[mpcg_pkg::OUT_DIV_LSB +: 3];
    c.loop_in_div = w[mpcg_pkg::IN_DIV_LSB +: 5];
    c.loop_fb_div = w[mpcg_pkg::FB_DIV_LSB +: 8];
    return c;
  endfunction

  function automatic logic [31:0] read_word(input logic [31:0] a,
      input mpcg_pkg::mpcg_pll_cfg_type c, input logic lock,
      input logic [20:0] sel, input logic [5:0] gate);
    logic [31:0] w;
    w = 32'h00000000;
    if (hits(a, mpcg_pkg::MEM_CFG_ADDR)) begin
      w[mpcg_pkg::DLL_PD_BIT] = c.dll_pd;
      w[mpcg_pkg::LOCK_BIT] = lock;
      w[mpcg_pkg::BYPASS_BIT] = c.pll_bypass;
      w[mpcg_pkg::BAND_LSB +: 3] = c.band;
      w[mpcg_pkg::OUT_DIV_LSB +: 3] = c.out_div;
      w[mpcg_pkg::IN_DIV_LSB +: 5] = c.loop_in_div;
      w[mpcg_pkg::FB_DIV_LSB +: 8] = c.loop_fb_div;
    end else if (hits(a, mpcg_pkg::GATE_ADDR)) begin
      w[mpcg_pkg::GATE_LSB +: mpcg_pkg::DOMAINS] = gate;
      w[mpcg_pkg::SEL_LSB +: mpcg_pkg::SEL_BITS] = sel;
    end
    return w;
  endfunction

  // Unselected or invalid source reads high, so the gate simply holds
  function automatic logic src_level(input logic [2:0] s, input logic [4:0] lv);
    src_level = (s < 3'(mpcg_pkg::PLL_SRCS)) ? lv[s] : 1'b1;
  endfunction

  assign take = ahb_req.hsel && ahb_req.hready && (ahb_req.htrans == mpcg_pkg::HTRANS_NONSEQ);

  // Write data arrives one cycle late, so reads forward it to stay coherent
  always_comb begin
    next_cfg = mem_pll_cfg;
    next_sel = clk_sel;
    next_gate = gate_ctl;
    if (wr_pend && wr_mem) begin
      next_cfg = cfg_from_word(hwdata);
    end
    if (wr_pend && wr_gate) begin
      next_sel = hwdata[mpcg_pkg::SEL_LSB +: mpcg_pkg::SEL_BITS];
      next_gate = hwdata[mpcg_pkg::GATE_LSB +: mpcg_pkg::DOMAINS];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_pend <= 1'b0;
      wr_mem <= 1'b0;
      wr_gate <= 1'b0;
    end else begin
      wr_pend <= take && ahb_req.hwrite;
      wr_mem <= hits(ahb_req.haddr, mpcg_pkg::MEM_CFG_ADDR);
      wr_gate <= hits(ahb_req.haddr, mpcg_pkg::GATE_ADDR);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (take && !ahb_req.hwrite) begin
        hrdata <= read_word(ahb_req.haddr, next_cfg, pll_locked, next_sel, next_gate);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mem_pll_cfg <= cfg_from_word(mpcg_pkg::MEM_CFG_RESET);
    end else begin
      mem_pll_cfg <= next_cfg;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      clk_sel <= mpcg_pkg::GATE_RESET[mpcg_pkg::SEL_LSB +: mpcg_pkg::SEL_BITS];
      gate_ctl <= mpcg_pkg::GATE_RESET[mpcg_pkg::GATE_LSB +: mpcg_pkg::DOMAINS];
    end else begin
      clk_sel <= next_sel;
      gate_ctl <= next_gate;
    end
  end

  // Domain i (display up to TV out) uses select slot i+1; slot 0 has no gate
  always_comb begin
    for (int i = 0; i < mpcg_pkg::DOMAINS; i++) begin
      src_low[i] = !src_level(clk_sel[(i + 1) * mpcg_pkg::SEL_W +: mpcg_pkg::SEL_W],
          pll_clk_level);
    end
  end

  // Moving only in the low phase keeps the divider from seeing a runt pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      gate_hold <= 6'h00;
    end else begin
      for (int i = 0; i < mpcg_pkg::DOMAINS; i++) begin
        if (src_low[i]) begin
          gate_hold[i] <= gate_ctl[i];
        end
      end
    end
  end

  sequence s_mem_write;
    wr_pend && wr_mem;
  endsequence

  sequence s_gate_write;
    wr_pend && wr_gate;
  endsequence

  sequence s_mem_read;
    take && !ahb_req.hwrite && hits(ahb_req.haddr, mpcg_pkg::MEM_CFG_ADDR) && !wr_pend;
  endsequence

  property p_dll_pd;
    @(posedge clk) disable iff (rst)
    s_mem_write |=> mem_pll_cfg.dll_pd == $past(hwdata[mpcg_pkg::DLL_PD_BIT]);
  endproperty
  a_dll_pd: assert property (p_dll_pd) else $error("DLL power-down not taken");

  property p_lock_read;
    @(posedge clk) disable iff (rst)
    s_mem_read |=> hrdata[mpcg_pkg::LOCK_BIT] == $past(pll_locked);
  endproperty
  a_lock_read: assert property (p_lock_read) else $error("Lock bit misread");

  property p_bypass;
    @(posedge clk) disable iff (rst)
    s_mem_write |=> mem_pll_cfg.pll_bypass == $past(hwdata[mpcg_pkg::BYPASS_BIT]);
  endproperty
  a_bypass: assert property (p_bypass) else $error("Bypass bit not taken");

  property p_dividers;
    @(posedge clk) disable iff (rst)
    s_mem_write |=> {mem_pll_cfg.out_div, mem_pll_cfg.loop_in_div, mem_pll_cfg.loop_fb_div}
        == $past(hwdata[15:0]);
  endproperty
  a_dividers: assert property (p_dividers) else $error("Divider fields wrong");

  property p_cfg_hold;
    @(posedge clk) disable iff (rst)
    !(wr_pend && wr_mem) |=> $stable(mem_pll_cfg);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("Config changed without write");

  property p_gate_write;
    @(posedge clk) disable iff (rst)
    s_gate_write |=> gate_ctl == $past(hwdata[27:22]) && clk_sel == $past(hwdata[20:0]);
  endproperty
  a_gate_write: assert property (p_gate_write) else $error("Gate register wrong");

  property p_gate_reset;
    @(posedge clk)
    rst |=> gate_hold == 6'h00 && gate_ctl == 6'h00 && mem_pll_cfg.out_div == 3'h0;
  endproperty
  a_gate_reset: assert property (p_gate_reset) else $error("Reset values wrong");

  property p_gate_follow;
    @(posedge clk) disable iff (rst)
    (src_low == 6'h3F) ##1 (src_low == 6'h3F) |-> gate_hold == $past(gate_ctl);
  endproperty
  a_gate_follow: assert property (p_gate_follow) else $error("Gate not following");

  property p_glitch_free;
    @(posedge clk) disable iff (rst)
    1'b1 |=> ((gate_hold ^ $past(gate_hold)) & ~$past(src_low)) == 6'h00;
  endproperty
  a_glitch_free: assert property (p_glitch_free) else $error("Gate moved while high");

  property p_sel_route;
    @(posedge clk) disable iff (rst)
    (clk_sel[5:3] == 3'h4) |-> src_low[0] == !pll_clk_level[4];
  endproperty
  a_sel_route: assert property (p_sel_route) else $error("Source select misrouted");

  property p_okay;
    @(posedge clk) disable iff (rst)
    take |=> hreadyout && !hresp;
  endproperty
  a_okay: assert property (p_okay) else $error("Bus answer not OKAY");
endmodule
`default_nettype wire

// ### tb/memory_pll_and_clock_gate_ctrl_bench.sv
/*
  Self-checking bench for the memory PLL configuration and clock gate block.
  Assumes the zero wait state AHB-Lite slave of mpcg_top, driven directly.
*/
`timescale 1ns/1ps
`default_nettype none
module memory_pll_and_clock_gate_ctrl_bench;
  typedef struct packed {
    logic [31:0] a;
    logic [31:0] w;
    logic lk;
  } mpcg_row_type;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0, hwrite = 1'b0, lock = 1'b1;
  logic [31:0] haddr = 32'h00000000, hwdata = 32'h00000000, hrdata, r;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [4:0] lvl = 5'h00;
  logic hreadyout, hresp;
  logic [5:0] gate_hold;
  logic [20:0] clk_sel;
  mpcg_pkg::mpcg_pll_cfg_type mem_pll_cfg;
  mpcg_pkg::mpcg_ahb_req_type ahb_req;
  int error_cnt = 0, checked = 0;
  mpcg_row_type rows [6] = '{
    '{32'h0000004C, 32'hFFFFFFFF, 1'b1}, '{32'h0000004C, 32'h0012A5C3, 1'b0},
    '{32'h0000004C, 32'h002A1F3C, 1'b1}, '{32'h000000F8, 32'h1AB1A223, 1'b1},
    '{32'h000000F8, 32'h0540A701, 1'b1}, '{32'h00000100, 32'hFFFFFFFF, 1'b1}};
  // Bus hready is the one slave's hreadyout
  assign ahb_req = {hsel, haddr, htrans, hwrite, hsize, hreadyout};
  mpcg_top mpcg_top_inst (.clk(clk), .rst(rst), .ahb_req(ahb_req), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pll_locked(lock),
    .pll_clk_level(lvl), .mem_pll_cfg(mem_pll_cfg), .gate_hold(gate_hold),
    .clk_sel(clk_sel));
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bounded wait so a stuck slave ends the run instead of hanging it
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      error_cnt++;
      $display("ERROR %0t: bus never ready", $time);
      tally_and_finish();
    end
  endtask
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] w);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= mpcg_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w;
    wait_ready();
    r = hrdata;
  endtask
  function automatic logic [31:0] exp_rd(input logic [31:0] a, w, input logic lk);
    if (a == mpcg_pkg::MEM_CFG_ADDR) return {10'h000, w[21], lk, w[19:0]};
    if (a == mpcg_pkg::GATE_ADDR) return {4'h0, w[27:22], 1'b0, w[20:0]};
    return 32'h00000000;
  endfunction
  task automatic reset_check;
    chk({30'h0, hreadyout, hresp}, 32'h00000002);
    chk(32'(mem_pll_cfg), 32'h00000000);
    chk(32'(gate_hold), 32'h00000000);
    chk(32'(clk_sel), 32'h00001800);
    ahb(1'b0, mpcg_pkg::MEM_CFG_ADDR, 32'h00000000);
    chk(r, mpcg_pkg::MEM_CFG_RESET);
    ahb(1'b0, mpcg_pkg::GATE_ADDR, 32'h00000000);
    chk(r, mpcg_pkg::GATE_RESET);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    reset_check();
    for (int i = 0; i < 6; i++) begin
      lock <= rows[i].lk;
      ahb(1'b1, rows[i].a, rows[i].w);
      ahb(1'b0, rows[i].a, 32'h00000000);
      chk(r, exp_rd(rows[i].a, rows[i].w, rows[i].lk));
      if (rows[i].a == mpcg_pkg::MEM_CFG_ADDR) begin
        chk(32'(mem_pll_cfg), {11'h000, rows[i].w[21], rows[i].w[19:0]});
        chk(32'(mem_pll_cfg.band), 32'(rows[i].w[18:16]));
      end
      if (rows[i].a == mpcg_pkg::GATE_ADDR) begin
        repeat (2) @(posedge clk);
        chk(32'(gate_hold), 32'(rows[i].w[27:22]));
        chk(32'(clk_sel), 32'(rows[i].w[20:0]));
      end
    end
    // Sources high: new gate settings must wait for a low source level
    lvl <= 5'h1F;
    ahb(1'b1, mpcg_pkg::GATE_ADDR, 32'h0FC00000);
    repeat (4) @(posedge clk);
    chk(32'(gate_hold), 32'h00000015);
    lvl <= 5'h1E;
    repeat (3) @(posedge clk);
    chk(32'(gate_hold), 32'h0000003F);
    // Display select 5 is no source, so its gate stays frozen
    lvl <= 5'h00;
    ahb(1'b1, mpcg_pkg::GATE_ADDR, 32'h00000028);
    repeat (3) @(posedge clk);
    chk(32'(gate_hold), 32'h00000001);
    // Gate first, move display onto the memory PLL, release only afterwards
    ahb(1'b1, mpcg_pkg::GATE_ADDR, 32'h0FC00028);
    ahb(1'b1, mpcg_pkg::GATE_ADDR, 32'h0FC00020);
    repeat (2) @(posedge clk);
    chk(32'(gate_hold), 32'h0000003F);
    ahb(1'b1, mpcg_pkg::GATE_ADDR, 32'h00000020);
    repeat (2) @(posedge clk);
    chk(32'(gate_hold), 32'h00000000);
    chk(32'(clk_sel), 32'h00000020);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    reset_check();
    tally_and_finish();
  end
endmodule
`default_nettype wire
